/* core/fsp_pkg.sv */
// Purpose: Shared constants for the flash status and write-protect block.
// Assumes: Mode 0 serial link, MSB first, system clock at 250 MHz.
// Notes:   Opcodes not fixed here are parameters of the core module.
package fsp_pkg;

    // Command opcodes
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_SMALL_WIPE   = 8'h20;

    // Status word field positions and reset value
    localparam int unsigned STAT_BUSY  = 0;
    localparam int unsigned STAT_LATCH = 1;
    localparam int unsigned STAT_PL_LO = 2;
    localparam int unsigned STAT_PL_HI = 5;
    localparam int unsigned STAT_QE    = 6;
    localparam int unsigned STAT_LOCK  = 7;
    localparam logic [7:0]  STATUS_RST = 8'h00;

    // Frame bit counts seen at the link
    localparam logic [5:0] CNT_OPCODE   = 6'h08;
    localparam logic [5:0] CNT_STAT_WR  = 6'h10;
    localparam logic [5:0] CNT_ADDR     = 6'h20;
    localparam logic [5:0] CNT_PROG_MIN = 6'h28;
    localparam logic [5:0] CNT_WRAP_TOP = 6'h2F;
    localparam logic [5:0] CNT_RST      = 6'h00;

    // System clock period
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Default protect table: level n shields the top n regions of the array
    localparam logic [23:0] ARRAY_TOP   = 24'h20_0000;
    localparam logic [23:0] REGION_STEP = 24'h01_0000;

    function automatic logic [15:0][23:0] prot_base_init();
        logic [15:0][23:0] t;
        t = '0;
        for (int i = 0; i < 16; i++) begin
            t[i] = 24'(ARRAY_TOP - 24'(i) * REGION_STEP);
        end
        return t;
    endfunction

endpackage

/* core/fsp_status_core.sv */
// Purpose: Status word, write latch, protect levels and lock modes of a serial flash.
// Assumes: Link logic runs on sclk_i; cs_n_i high clears the frame state.
// Notes:   Frame captures are read by the system side only after select rises.
`timescale 1ns/1ps

module fsp_status_core
    import fsp_pkg::*;
#(
    parameter int unsigned          STATUS_WRITE_TIME_NS = 1000,
    parameter int unsigned          PROGRAM_TIME_NS      = 2000,
    parameter int unsigned          ERASE_TIME_NS        = 4000,
    parameter logic [7:0]           OP_PAGE_WRITE        = 8'hA1,
    parameter logic [7:0]           OP_QUAD_PAGE_WRITE   = 8'hA2,
    parameter logic [7:0]           OP_LARGE_WIPE        = 8'hA3,
    parameter logic [7:0]           OP_CHIP_WIPE         = 8'hA4,
    parameter logic [15:0][23:0]    PROT_BASE            = prot_base_init()
) (
    // System clock and reset
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    // Serial link from the host
    input  wire logic               sclk_i,
    input  wire logic               cs_n_i,
    input  wire logic               si_i,
    input  wire logic               wp_n_i,
    output logic                    so_o,
    output logic                    so_oe_o,
    // Status view
    output logic [7:0]              status_o,
    output logic                    quad_io_enable_o,
    output logic                    hard_lock_mode_o
);

    // Self-timed cycle lengths, rounded up to whole clocks
    localparam logic [31:0] SW_CYC   =
        32'((STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] PROG_CYC =
        32'((PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] ERASE_CYC =
        32'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Link state cleared whenever select is high
    typedef struct packed {
        logic [5:0] cnt;
        logic       rd;
        logic [7:0] tx;
    } fsp_frame_t;

    // Link captures that survive the end of a frame
    typedef struct packed {
        logic [31:0] sh;
        logic [7:0]  op;
        logic [5:0]  cnt_last;
        logic [2:0]  req_sync;
        logic [7:0]  copy;
    } fsp_cap_t;

    // Output stage launched on the falling link edge
    typedef struct packed {
        logic so;
        logic oe;
    } fsp_out_t;

    // System side state
    typedef struct packed {
        logic [1:0]  cs_sync;
        logic        cs_prev;
        logic [1:0]  wp_sync;
        logic [1:0]  ack_sync;
        logic [7:0]  stat;
        logic [31:0] tmr;
        logic        req;
        logic [7:0]  shadow;
    } fsp_core_t;

    fsp_frame_t fr_r;
    fsp_frame_t fr_nxt;
    fsp_cap_t   cap_r;
    fsp_cap_t   cap_nxt;
    fsp_out_t   out_r;
    fsp_out_t   out_nxt;
    fsp_core_t  st_r;
    fsp_core_t  st_nxt;

    logic       end_evt;
    logic       idle;
    logic       hard_lock;
    logic       prot_hit;
    logic [3:0] level;
    logic       wr_ok;
    logic       wr_req;

    // Link side: bit count, status read flag and transmit byte
    always_comb begin
        logic [7:0] op_now;
        op_now = {cap_r.sh[6:0], si_i};
        fr_nxt = fr_r;
        fr_nxt.cnt = (fr_r.cnt == CNT_WRAP_TOP) ? CNT_PROG_MIN : 6'(fr_r.cnt + 6'h01);
        if (fr_r.cnt == 6'(CNT_OPCODE - 6'h01) && op_now == OP_STATUS_READ) begin
            fr_nxt.rd = 1'b1;
        end
        if (fr_nxt.cnt[2:0] == 3'h0) begin
            fr_nxt.tx = cap_r.copy;
        end else begin
            fr_nxt.tx = {fr_r.tx[6:0], 1'b0};
        end
    end

    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fr_r <= '{cnt: CNT_RST, rd: 1'b0, tx: STATUS_RST};
        end else begin
            fr_r <= fr_nxt;
        end
    end

    // Link side: opcode, address and data capture, status word handshake
    always_comb begin
        cap_nxt = cap_r;
        if (fr_r.cnt < CNT_ADDR) begin
            cap_nxt.sh = {cap_r.sh[30:0], si_i};
        end
        if (fr_r.cnt == 6'(CNT_OPCODE - 6'h01)) begin
            cap_nxt.op = {cap_r.sh[6:0], si_i};
        end
        cap_nxt.cnt_last = fr_nxt.cnt;
        cap_nxt.req_sync = {cap_r.req_sync[1:0], st_r.req};
        // Take the word only once req has crossed, so the shadow is already steady
        if (cap_r.req_sync[2] != cap_r.req_sync[1]) begin
            cap_nxt.copy = st_r.shadow;
        end
    end

    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cap_r <= '0;
        end else begin
            cap_r <= cap_nxt;
        end
    end

    // Falling edge launches the status bit so the host samples it on the rise
    always_comb begin
        out_nxt.so = fr_r.tx[7];
        out_nxt.oe = fr_r.rd;
    end

    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // Decode of the finished frame; captures are stable once select is high
    assign end_evt   = st_r.cs_sync[1] & ~st_r.cs_prev;
    assign idle      = ~st_r.stat[STAT_BUSY];
    assign level     = st_r.stat[STAT_PL_HI:STAT_PL_LO];
    assign hard_lock = st_r.stat[STAT_LOCK] & ~st_r.wp_sync[1]
                       & ~st_r.stat[STAT_QE];
    assign prot_hit  = (level != 4'h0) && (cap_r.sh[23:0] >= PROT_BASE[level]);
    assign wr_req    = end_evt && cap_r.op == OP_STATUS_WRITE;
    assign wr_ok     = wr_req && cap_r.cnt_last == CNT_STAT_WR && idle
                       && st_r.stat[STAT_LATCH] && !hard_lock;

    // System side: status word, self-timed cycles and word crossing
    always_comb begin
        st_nxt = st_r;
        st_nxt.cs_sync  = {st_r.cs_sync[0], cs_n_i};
        st_nxt.cs_prev  = st_r.cs_sync[1];
        st_nxt.wp_sync  = {st_r.wp_sync[0], wp_n_i};
        st_nxt.ack_sync = {st_r.ack_sync[0], cap_r.req_sync[2]};
        // Hand the status word to the link when the last copy was taken
        if (st_r.ack_sync[1] == st_r.req && st_r.shadow != st_r.stat) begin
            st_nxt.shadow = st_r.stat;
            st_nxt.req    = ~st_r.req;
        end
        // Running cycle counts down, then frees the device
        if (!idle) begin
            st_nxt.tmr = 32'(st_r.tmr - 32'h1);
            if (st_r.tmr == 32'h1) begin
                st_nxt.stat[STAT_BUSY]  = 1'b0;
                st_nxt.stat[STAT_LATCH] = 1'b0;
            end
        end
        if (end_evt && idle) begin
            case (cap_r.op)
                OP_LATCH_SET: begin
                    if (cap_r.cnt_last == CNT_OPCODE) begin
                        st_nxt.stat[STAT_LATCH] = 1'b1;
                    end
                end
                OP_LATCH_CLEAR: begin
                    if (cap_r.cnt_last == CNT_OPCODE) begin
                        st_nxt.stat[STAT_LATCH] = 1'b0;
                    end
                end
                OP_STATUS_WRITE: begin
                    if (wr_ok) begin
                        st_nxt.stat[STAT_LOCK:STAT_PL_LO] =
                            cap_r.sh[STAT_LOCK:STAT_PL_LO];
                        st_nxt.stat[STAT_BUSY] = 1'b1;
                        st_nxt.tmr = SW_CYC;
                    end
                end
                OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE: begin
                    if (st_r.stat[STAT_LATCH] && !prot_hit && cap_r.cnt_last >= CNT_PROG_MIN
                        && cap_r.cnt_last[2:0] == 3'h0) begin
                        st_nxt.stat[STAT_BUSY] = 1'b1;
                        st_nxt.tmr = PROG_CYC;
                    end
                end
                OP_SMALL_WIPE, OP_LARGE_WIPE: begin
                    if (st_r.stat[STAT_LATCH] && !prot_hit
                        && cap_r.cnt_last == CNT_ADDR) begin
                        st_nxt.stat[STAT_BUSY] = 1'b1;
                        st_nxt.tmr = ERASE_CYC;
                    end
                end
                OP_CHIP_WIPE: begin
                    if (st_r.stat[STAT_LATCH] && level == 4'h0
                        && cap_r.cnt_last == CNT_OPCODE) begin
                        st_nxt.stat[STAT_BUSY] = 1'b1;
                        st_nxt.tmr = ERASE_CYC;
                    end
                end
                default: begin
                    st_nxt.tmr = st_nxt.tmr;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_r <= '{cs_sync: 2'h3, cs_prev: 1'b1, wp_sync: 2'h3, ack_sync: 2'h0,
                      stat: STATUS_RST, tmr: 32'h0, req: 1'b0, shadow: STATUS_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pins and status view
    assign so_o             = out_r.so;
    assign so_oe_o          = out_r.oe;
    assign status_o         = st_r.stat;
    assign quad_io_enable_o = st_r.stat[STAT_QE];
    assign hard_lock_mode_o = hard_lock;

    // Checks on the system side
    default clocking chk_cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_busy_has_timer: assert property (
        st_r.stat[STAT_BUSY] |-> st_r.tmr != 32'h0)
        else $error("busy flag set with no cycle running");

    chk_write_needs_latch: assert property (
        (wr_req && idle && !st_r.stat[STAT_LATCH]) |=> !st_r.stat[STAT_BUSY])
        else $error("status write ran without the latch");

    chk_hard_lock_refuse: assert property (
        (wr_req && hard_lock) |=> $stable(st_r.stat[STAT_LOCK:STAT_PL_LO]))
        else $error("status write altered bits in hard lock");

    chk_chip_wipe_level: assert property (
        (end_evt && idle && cap_r.op == OP_CHIP_WIPE && level != 4'h0)
        |=> !st_r.stat[STAT_BUSY] && $stable(st_r.stat[STAT_LATCH]))
        else $error("whole-array wipe started with protect levels set");

    chk_protect_discard: assert property (
        (end_evt && idle && prot_hit && (cap_r.op == OP_SMALL_WIPE
         || cap_r.op == OP_PAGE_WRITE)) |=> !st_r.stat[STAT_BUSY]
         && $stable(st_r.stat[STAT_LATCH]))
        else $error("protected region command executed");

    chk_cycle_end_latch: assert property (
        $fell(st_r.stat[STAT_BUSY]) |-> !st_r.stat[STAT_LATCH] && st_r.tmr == 32'h0)
        else $error("latch survived end of self-timed cycle");

    chk_write_loads_bits: assert property (
        wr_ok |=> st_r.stat[STAT_LOCK:STAT_PL_LO] == $past(cap_r.sh[7:2])
                  && st_r.stat[STAT_LATCH] && st_r.tmr == SW_CYC)
        else $error("status write did not load the received byte");

    chk_partial_byte_reject: assert property (
        (wr_req && idle && cap_r.cnt_last != CNT_STAT_WR)
        |=> $stable(st_r.stat[STAT_LOCK:STAT_PL_LO]) && !st_r.stat[STAT_BUSY])
        else $error("status write with broken byte count executed");

    chk_levels_only_by_write: assert property (
        !wr_ok |=> $stable(st_r.stat[STAT_LOCK:STAT_PL_LO]))
        else $error("protect levels changed without a status write");

    chk_quad_no_lock: assert property (
        st_r.stat[STAT_QE] |-> !hard_lock_mode_o)
        else $error("hard lock active in quad mode");

    // Cycle timing and command acceptance
    chk_timer_counts: assert property (
        (!idle && st_r.tmr != 32'h1) |=> st_r.stat[STAT_BUSY]
        && st_r.tmr == 32'($past(st_r.tmr) - 32'h1))
        else $error("self-timed cycle did not count down by one");

    chk_cycle_release: assert property (
        (!idle && st_r.tmr == 32'h1) |=> idle && !st_r.stat[STAT_LATCH])
        else $error("self-timed cycle did not release busy and latch");

    chk_reject_no_busy: assert property (
        (wr_req && idle && !wr_ok) |=> !st_r.stat[STAT_BUSY]
        && $stable(st_r.stat[STAT_LOCK:STAT_LATCH]))
        else $error("rejected status write changed the status word");

    chk_quad_write_ok: assert property (
        (wr_req && idle && st_r.stat[STAT_QE] && st_r.stat[STAT_LATCH]
         && cap_r.cnt_last == CNT_STAT_WR) |=> st_r.stat[STAT_BUSY])
        else $error("status write refused in quad mode");

    chk_soft_lock_write: assert property (
        (wr_req && idle && st_r.stat[STAT_LATCH] && st_r.wp_sync[1]
         && cap_r.cnt_last == CNT_STAT_WR) |=> st_r.stat[STAT_BUSY])
        else $error("status write refused with the pin high");

    chk_latch_set_cmd: assert property (
        (end_evt && idle && cap_r.op == OP_LATCH_SET && cap_r.cnt_last == CNT_OPCODE)
        |=> st_r.stat[STAT_LATCH])
        else $error("latch set command did not set the latch");

    chk_latch_clear_cmd: assert property (
        (end_evt && idle && cap_r.op == OP_LATCH_CLEAR && cap_r.cnt_last == CNT_OPCODE)
        |=> !st_r.stat[STAT_LATCH])
        else $error("latch clear command did not clear the latch");

    chk_chip_wipe_open: assert property (
        (end_evt && idle && cap_r.op == OP_CHIP_WIPE && level == 4'h0
         && st_r.stat[STAT_LATCH] && cap_r.cnt_last == CNT_OPCODE) |=> st_r.stat[STAT_BUSY])
        else $error("whole-array wipe refused with levels clear");

    // Main scenarios
    cov_status_write: cover property (wr_ok ##1 st_r.stat[STAT_BUSY]);
    cov_hard_lock_reject: cover property (wr_req && hard_lock);
    cov_chip_wipe: cover property (end_evt && cap_r.op == OP_CHIP_WIPE && idle);
    cov_status_read: cover property (@(posedge sclk_i) fr_r.rd && fr_r.cnt == 6'h10);
    cov_page_write: cover property (end_evt && idle
        && (cap_r.op == OP_PAGE_WRITE || cap_r.op == OP_QUAD_PAGE_WRITE));

endmodule

/* sim/fsp_host_model.sv */
// Purpose: Host side of the serial link, framing commands and reading answers.
// Assumes: Mode 0, 64 ns link clock that stands still between frames.
// Notes:   A released data line reads as the inverse of its last value.
`timescale 1ns/1ps
module fsp_host_model (
    // Answer from the device
    input  wire logic so_i,
    input  wire logic so_oe_i,
    // Link outputs
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o
);
    // Undriven line shows the opposite of what the device left on it
    wire so_line = so_oe_i ? so_i : ~so_i;

    // Idle link at time zero; scheduled so the device sees select rise as an edge
    initial begin
        sclk_o <= 1'b0;
        cs_n_o <= 1'b1;
        si_o   <= 1'b0;
    end

    // One link clock: data set while low, answer sampled before the rise
    task automatic clk_bit(input logic b, output logic s);
        si_o   <= b;
        #32;
        s      = so_line;
        sclk_o <= 1'b1;
        #32;
        sclk_o <= 1'b0;
    endtask

    // Whole frame: opcode first, bytes MSB first, optional stray bits, read bytes
    task automatic frame(input logic [7:0] q[$], input int extra, input int rd,
                         output logic [15:0] rx);
        logic s;
        #1.3;
        cs_n_o <= 1'b0;
        #32;
        foreach (q[i]) begin
            for (int b = 7; b >= 0; b--) begin
                clk_bit(q[i][b], s);
            end
        end
        repeat (extra) clk_bit(1'b0, s);
        rx = '0;
        for (int k = 0; k < rd * 8; k++) begin
            clk_bit(1'b0, s);
            rx = {rx[14:0], s};
        end
        #32;
        cs_n_o <= 1'b1;
        #40;
    endtask
endmodule

/* sim/flash_status_protect_test.sv */
// Purpose: Self-checking bench for the status word and write-protect logic.
// Assumes: Host model frames every command; status write cycle set to 1000 cycles.
// Notes:   Second status byte of a read is judged, the first may lag one update.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module flash_status_protect_test;
    import fsp_pkg::*;
    localparam int unsigned SW_NS     = 4000;
    localparam logic [7:0]  CHIP_WIPE = 8'hA4;
    localparam logic [7:0]  PAGE_WR   = 8'hA1;
    localparam logic [7:0]  QUAD_WR   = 8'hA2;
    localparam logic [7:0]  LARGE_WP  = 8'hA3;
    logic        mclk_i    = 1'b0;
    logic        sys_rst_i;
    logic        wp_n_i    = 1'b1;
    logic        sclk, cs_n, si, so, so_oe, qe, hl;
    logic [7:0]  st;
    logic [15:0] rx;
    int          mismatches  = 0;
    int          check_count = 0;

    // System clock
    always #2 mclk_i = ~mclk_i;

    fsp_status_core #(
        .STATUS_WRITE_TIME_NS(SW_NS), .OP_PAGE_WRITE(PAGE_WR), .OP_QUAD_PAGE_WRITE(QUAD_WR),
        .OP_LARGE_WIPE(LARGE_WP), .OP_CHIP_WIPE(CHIP_WIPE)) fsp_status_core_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
        .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .status_o(st),
        .quad_io_enable_o(qe), .hard_lock_mode_o(hl));
    fsp_host_model fsp_host_model_i (
        .so_i(so), .so_oe_i(so_oe), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] q[$], input int extra);
        fsp_host_model_i.frame(q, extra, 0, rx);
    endtask

    // Latch set, then status write frame
    task automatic sw(input logic [7:0] v, input int extra);
        send('{OP_LATCH_SET}, 0);
        send('{OP_STATUS_WRITE, v}, extra);
    endtask

    task automatic rd();
        fsp_host_model_i.frame('{OP_STATUS_READ}, 0, 2, rx);
    endtask

    // Bounded poll of the busy flag
    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000 && st[STAT_BUSY] !== 1'b0; i++) @(posedge mclk_i);
        if (i == 3000) begin
            mismatches++;
            $display("[FAIL] busy_clear expected 0 seen %h", st[STAT_BUSY]);
            stop_test();
        end
    endtask

    task automatic wp(input logic v);
        @(posedge mclk_i) wp_n_i <= v;
        repeat (6) @(posedge mclk_i);
    endtask

    task automatic t_reset();
        `CHK("status_o", STATUS_RST, st)
        rd();
        `CHK("read_twice", {STATUS_RST, STATUS_RST}, rx)
        `CHK("hard_lock", 1'b0, hl)
        $display("test reset done");
    endtask

    task automatic t_latch();
        send('{OP_STATUS_WRITE, 8'h3C}, 0);
        `CHK("write_no_latch", 8'h00, st)
        send('{OP_LATCH_SET}, 0);
        `CHK("latch_set", 8'h02, st)
        send('{OP_LATCH_CLEAR}, 0);
        `CHK("latch_clear", 8'h00, st)
        $display("test latch done");
    endtask

    task automatic t_write();
        sw(8'hBC, 0);
        `CHK("write_busy", 8'hBF, st)
        rd();
        `CHK("read_in_busy", 2'b11, rx[1:0])
        wait_idle();
        `CHK("write_done", 8'hBC, st)
        rd();
        `CHK("read_levels", 8'hBC, rx[7:0])
        sw(8'h00, 1);
        `CHK("odd_bits", 8'hBE, st)
        send('{OP_LATCH_CLEAR}, 0);
        $display("test write done");
    endtask

    task automatic t_lock();
        wp(1'b0);
        `CHK("hard_lock_on", 1'b1, hl)
        sw(8'h00, 0);
        `CHK("hard_refuse", 8'hBE, st)
        wp(1'b1);
        `CHK("hard_lock_off", 1'b0, hl)
        sw(8'hC0, 0);
        wait_idle();
        `CHK("soft_lock_write", 8'hC0, st)
        `CHK("quad_io", 1'b1, qe)
        wp(1'b0);
        `CHK("quad_no_lock", 1'b0, hl)
        sw(8'h00, 0);
        wait_idle();
        `CHK("quad_write", 8'h00, st)
        sw(8'h08, 0);
        wait_idle();
        `CHK("unlocked_write", 8'h08, st)
        wp(1'b1);
        $display("test lock done");
    endtask

    task automatic t_wipe();
        send('{OP_LATCH_SET}, 0);
        send('{CHIP_WIPE}, 0);
        `CHK("chip_wipe_refused", 8'h0A, st)
        send('{OP_SMALL_WIPE, 8'h1F, 8'h00, 8'h00}, 0);
        `CHK("protected_wipe", 8'h0A, st)
        send('{OP_SMALL_WIPE, 8'h00, 8'h00, 8'h00}, 0);
        `CHK("open_wipe_busy", 1'b1, st[STAT_BUSY])
        wait_idle();
        `CHK("wipe_done", 8'h08, st)
        $display("test wipe done");
    endtask

    task automatic t_program();
        send('{OP_LATCH_SET}, 0);
        send('{PAGE_WR, 8'h1F, 8'h00, 8'h00, 8'h5A}, 0);
        `CHK("protected_prog", 8'h0A, st)
        send('{QUAD_WR, 8'h00, 8'h00, 8'h00, 8'h5A}, 0);
        `CHK("open_prog_busy", 8'h0B, st)
        wait_idle();
        `CHK("prog_done", 8'h08, st)
        send('{OP_LATCH_SET}, 0);
        send('{LARGE_WP, 8'h00, 8'h00, 8'h00}, 0);
        `CHK("large_wipe_busy", 8'h0B, st)
        wait_idle();
        sw(8'h00, 0);
        wait_idle();
        send('{OP_LATCH_SET}, 0);
        send('{CHIP_WIPE}, 0);
        `CHK("chip_wipe_open", 8'h03, st)
        wait_idle();
        `CHK("chip_wipe_done", 8'h00, st)
        $display("test program done");
    endtask

    // Main sequence
    initial begin
        sys_rst_i <= 1'b1; // Edge at time zero also clears the link-side captures
        repeat (3) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        t_reset();
        t_latch();
        t_write();
        t_lock();
        t_wipe();
        t_program();
        stop_test();
    end
endmodule
